// File: rtl/ldp_pkg.sv
// Shared constants and types for the logic domain power-down controller.
// Assumes a single 125 MHz system clock and word-only AHB-Lite accesses.
package ldp_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int NUM_DOM = 4;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PGOOD_DELAY_NS = 1000;
  localparam int PGOOD_CYCLES = (PGOOD_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int PGOOD_CNT_W = 8;
  localparam int STRAP_SETTLE = 4;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_CLK_OFF_SET = 32'hFFFF0000;
  localparam logic [31:0] ADDR_PWR_CTRL = 32'hFFFF0004;
  localparam logic [31:0] ADDR_PWR_STATE = 32'hFFFF0008;
  localparam logic [31:0] ADDR_CMP_STATUS = 32'hFFFF00B0;
  localparam logic [31:0] ADDR_CMP_INJECT = 32'hFFFF00B4;
  localparam logic [31:0] ADDR_ERR_IRQ_EN_SET = 32'hFFFFF540;
  localparam logic [31:0] ADDR_ERR_PIN_EN_SET = 32'hFFFFF544;
  localparam logic [31:0] ADDR_ERR_STATUS = 32'hFFFFF558;

  // ---------------------------------------------------------------
  // Field positions, codes and reset values
  // ---------------------------------------------------------------
  localparam int CMP_FLAG_LSB = 16;
  localparam int ERR_CH38_BIT = 6;
  localparam int ERR_CH39_BIT = 7;
  localparam int PWR_CODE_W = 4;
  localparam logic [3:0] PWR_CODE_OFF = 4'hA;
  localparam logic [1:0] PST_ON = 2'h3;
  localparam logic [1:0] PST_INIT = 2'h2;
  localparam logic [1:0] PST_GOING = 2'h1;
  localparam logic [1:0] PST_OFF = 2'h0;
  localparam logic [15:0] PWR_CTRL_RST = 16'h0000;
  localparam logic [1:0] ERR_EN_RST = 2'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ, HTRANS_SEQ} ldp_htrans_t;

  typedef struct packed {
    logic start;
    logic strap_off;
    logic clk_off;
    logic code_off;
    logic inject;
  } ldp_dom_req_t;

endpackage

// File: rtl/ldp_sync.sv
// Three-stage synchroniser with agreement filter for a pin-level input.
// Assumes the input is asynchronous to hclk; output changes when stages two and three agree.
`timescale 1ns/100ps
module ldp_sync
(
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic pin_in, // Asynchronous level.
  output logic level_out // Filtered synchronous level.
);
  import ldp_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the two later stages agree, which rejects single-cycle glitches.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_out <= 1'b0;
    else if (s2_q == s3_q)
      level_out <= s3_q;
  end

endmodule

// File: rtl/ldp_domain.sv
// Power-state machine for one switchable logic domain.
// Assumes the caller raises start once the strap synchroniser has settled.
`timescale 1ns/100ps
module ldp_domain
(
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire ldp_pkg::ldp_dom_req_t req, // Control inputs.
  output logic [1:0] pstate // Reported power state.
);
  import ldp_pkg::*;

  typedef enum {DOM_INIT, DOM_ON, DOM_GOING, DOM_OFF} ldp_dom_st_t;

  ldp_dom_st_t st_q;
  logic [PGOOD_CNT_W-1:0] cnt_q;

  // Off is terminal: only reset leaves it, so no write can bring the domain back.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= DOM_INIT;
    else
    begin
      case (st_q)
        DOM_INIT:
          if (req.start)
            st_q <= req.strap_off ? DOM_OFF : DOM_ON;
        DOM_ON:
          if (req.clk_off && req.code_off)
            st_q <= DOM_GOING;
        DOM_GOING:
          if (cnt_q == PGOOD_CNT_W'(PGOOD_CYCLES - 1))
            st_q <= DOM_OFF;
        DOM_OFF:
          st_q <= DOM_OFF;
        default:
          st_q <= DOM_INIT;
      endcase
    end
  end

  // Power-good wait counter runs only while the domain is going down.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= '0;
    else if (st_q == DOM_GOING)
      cnt_q <= cnt_q + 1'b1;
    else
      cnt_q <= '0;
  end

  // State encoding, with a test inversion hook used by the checker copy only.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pstate <= PST_INIT;
    else
    begin
      case (st_q)
        DOM_ON: pstate <= PST_ON ^ {2{req.inject}};
        DOM_GOING: pstate <= PST_GOING ^ {2{req.inject}};
        DOM_OFF: pstate <= PST_OFF ^ {2{req.inject}};
        default: pstate <= PST_INIT ^ {2{req.inject}};
      endcase
    end
  end

endmodule

// File: rtl/ldp_top.sv
// Logic domain power controller with lockstep compare and error channel flags.
// Assumes an AHB-Lite master on hclk and factory strap pins that are asynchronous.
`timescale 1ns/100ps

module ldp_top
(
  input wire logic hclk, // System clock, 125 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire ldp_pkg::ldp_htrans_t htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Response, always OKAY.
  input wire logic [ldp_pkg::NUM_DOM-1:0] strap_dom_off, // Factory off straps, asynchronous.
  output logic irq, // Level interrupt.
  output logic error_out_n // Error pin, active low.
);
  import ldp_pkg::*;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] addr_q;
  logic take;
  logic [31:0] rd_word;
  logic wr_en;

  // Only NONSEQ or SEQ with the bus ready starts a transfer; IDLE and BUSY are ignored.
  // The response is always OKAY, since an unmapped address is harmless here.
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_en = wr_pend_q;
  assign hresp = 1'b0;

  // Writes finish with no wait state; reads add one so the data comes from a flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take)
        addr_q <= haddr;
    end
  end

  // Read data is loaded during the wait state, after any earlier write has landed.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
    end
    else
    begin
      hreadyout <= !(take && !hwrite);
      if (rd_pend_q && !hreadyout)
        hrdata <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [NUM_DOM-1:0] clk_off_q;
  logic [15:0] pwr_ctrl_q;
  logic [NUM_DOM-1:0] inject_q;
  logic [1:0] irq_en_q;
  logic [1:0] pin_en_q;

  // Clock-off and enable registers are set-only; reset is the one way back.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_off_q <= '0;
      pwr_ctrl_q <= PWR_CTRL_RST;
      inject_q <= '0;
      irq_en_q <= ERR_EN_RST;
      pin_en_q <= ERR_EN_RST;
    end
    else if (wr_en)
    begin
      // Unmapped writes fall to the default branch and change nothing.
      case (addr_q)
        ADDR_CLK_OFF_SET: clk_off_q <= clk_off_q | hwdata[NUM_DOM-1:0];
        ADDR_PWR_CTRL: pwr_ctrl_q <= hwdata[15:0];
        ADDR_CMP_INJECT: inject_q <= hwdata[NUM_DOM-1:0];
        ADDR_ERR_IRQ_EN_SET: irq_en_q <= irq_en_q | hwdata[ERR_CH39_BIT:ERR_CH38_BIT];
        ADDR_ERR_PIN_EN_SET: pin_en_q <= pin_en_q | hwdata[ERR_CH39_BIT:ERR_CH38_BIT];
        default: clk_off_q <= clk_off_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Strap capture and domain state machines
  // ---------------------------------------------------------------
  logic [NUM_DOM-1:0] strap_sync;
  logic [2:0] settle_q;
  logic start;
  logic [NUM_DOM-1:0][1:0] main_st;
  logic [NUM_DOM-1:0][1:0] chk_st;
  logic [NUM_DOM-1:0] mismatch;

  // Straps are taken only after the synchronisers have had time to fill.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      settle_q <= 3'h0;
    else if (!start)
      settle_q <= settle_q + 3'h1;
  end
  // Start stays high once reached because the counter stops; only reset restarts it.
  assign start = (settle_q == 3'(STRAP_SETTLE));

  // Each domain runs a controller and an identical checker copy; only a test hook differs.
  generate
    for (genvar i = 0; i < NUM_DOM; i++)
    begin : g_dom
      ldp_dom_req_t req_main;
      ldp_dom_req_t req_chk;
      assign req_main.start = start;
      assign req_main.strap_off = strap_sync[i];
      assign req_main.clk_off = clk_off_q[i];
      assign req_main.code_off = (pwr_ctrl_q[i*PWR_CODE_W +: PWR_CODE_W] == PWR_CODE_OFF);
      assign req_main.inject = 1'b0;
      assign req_chk = '{start: req_main.start, strap_off: req_main.strap_off,
                         clk_off: req_main.clk_off, code_off: req_main.code_off,
                         inject: inject_q[i]};
      // Each strap passes its own synchroniser before either copy sees it.
      ldp_sync u_sync
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(strap_dom_off[i]),
        .level_out(strap_sync[i])
      );
      ldp_domain u_main
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(req_main),
        .pstate(main_st[i])
      );
      ldp_domain u_chk
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(req_chk),
        .pstate(chk_st[i])
      );
      // Both copies see the same start, strap and power-down inputs, so a deliberate power-down never disagrees.
      assign mismatch[i] = (main_st[i] != chk_st[i]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Compare flags and error channels
  // ---------------------------------------------------------------
  logic [NUM_DOM-1:0] cmp_q;
  logic [1:0] err_q;
  logic [1:0] err_set;
  logic cmp_clr_wr;
  logic err_clr_wr;

  // Clear strobes act in the write data phase, where hwdata stands.
  assign cmp_clr_wr = wr_en && (addr_q == ADDR_CMP_STATUS);
  assign err_clr_wr = wr_en && (addr_q == ADDR_ERR_STATUS);
  assign err_set = {|mismatch[3:2], |mismatch[1:0]};

  // A persisting mismatch wins over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmp_q <= '0;
    else if (cmp_clr_wr)
      cmp_q <= (cmp_q & ~hwdata[CMP_FLAG_LSB +: NUM_DOM]) | mismatch;
    else
      cmp_q <= cmp_q | mismatch;
  end

  // Channel 38 covers domains 0 and 1, channel 39 domains 2 and 3.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      err_q <= 2'h0;
    else if (err_clr_wr)
      err_q <= (err_q & ~hwdata[ERR_CH39_BIT:ERR_CH38_BIT]) | err_set;
    else
      err_q <= err_q | err_set;
  end

  // Outputs are registered so they never glitch on the pin.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
      error_out_n <= 1'b1;
    end
    else
    begin
      irq <= |(err_q & irq_en_q);
      error_out_n <= !(|(err_q & pin_en_q));
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Unmapped addresses read as zero.
  always_comb
  begin
    rd_word = 32'h00000000;
    case (addr_q)
      ADDR_CLK_OFF_SET: rd_word[NUM_DOM-1:0] = clk_off_q;
      ADDR_PWR_CTRL: rd_word[15:0] = pwr_ctrl_q;
      ADDR_PWR_STATE: rd_word[2*NUM_DOM-1:0] = main_st;
      ADDR_CMP_STATUS: rd_word[CMP_FLAG_LSB +: NUM_DOM] = cmp_q;
      ADDR_CMP_INJECT: rd_word[NUM_DOM-1:0] = inject_q;
      ADDR_ERR_IRQ_EN_SET: rd_word[ERR_CH39_BIT:ERR_CH38_BIT] = irq_en_q;
      ADDR_ERR_PIN_EN_SET: rd_word[ERR_CH39_BIT:ERR_CH38_BIT] = pin_en_q;
      ADDR_ERR_STATUS: rd_word[ERR_CH39_BIT:ERR_CH38_BIT] = err_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // All checks run on hclk and stand down while reset is low.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // The checker copy follows its inject bit one cycle late, so the clean check waits a cycle.
  AST_NO_FALSE_CMP: assert property (!(|inject_q) && !(|$past(inject_q)) |-> !(|mismatch))
    else $error("Compare mismatch without injected fault.");
  // A strapped domain reports off two cycles after start rises.
  AST_STRAP_OFF: assert property ($rose(start) && strap_sync[3]
    |=> ##1 main_st[3] == PST_OFF)
    else $error("Strapped domain did not report off.");
  AST_ERR_SET: assert property (err_set[0] |=> err_q[0])
    else $error("Channel 38 flag not set on mismatch.");
  AST_STAY_OFF: assert property (main_st[0] == PST_OFF |=> main_st[0] == PST_OFF)
    else $error("Domain left off state without reset.");
  // The going-down state stands for the whole power-good wait and then ends in off.
  AST_PG_DELAY: assert property ($rose(main_st[0] == PST_GOING)
    |-> (main_st[0] == PST_GOING)[*8])
    else $error("Power-good wait ended too early.");
  AST_PG_DONE: assert property ($rose(main_st[0] == PST_GOING)
    |-> ##124 main_st[0] == PST_GOING ##1 main_st[0] == PST_OFF)
    else $error("Power-good wait did not end in time.");
  AST_CMP_RESET: assert property (cmp_clr_wr && mismatch[0] |=> cmp_q[0])
    else $error("Persisting mismatch lost on clear.");
  AST_GENUINE: assert property (mismatch[2] |=> err_q[1])
    else $error("Mismatch did not reach channel 39.");
  // One-writes clear idle flags, zero-writes leave every flag alone.
  AST_W1C_ZERO: assert property (err_clr_wr && !hwdata[ERR_CH38_BIT] && err_q[0]
    |=> err_q[0])
    else $error("Writing zero cleared a flag.");
  AST_W1C_ONE: assert property (cmp_clr_wr && hwdata[CMP_FLAG_LSB] && !mismatch[0]
    |=> !cmp_q[0])
    else $error("Writing one did not clear a compare flag.");
  AST_ERR_CLR: assert property (err_clr_wr && hwdata[ERR_CH39_BIT] && !err_set[1]
    |=> !err_q[1])
    else $error("Writing one did not clear an error flag.");
  // Interrupt and pin follow an enabled flag one cycle later.
  AST_IRQ: assert property ((err_q & irq_en_q) != 2'h0 |=> irq)
    else $error("Interrupt not raised for enabled flag.");
  AST_PIN: assert property ((err_q & pin_en_q) != 2'h0 |=> !error_out_n)
    else $error("Error pin not driven for enabled flag.");
  // A power code without the clock-off bit never starts power-down.
  AST_CODE_ALONE: assert property (main_st[0] == PST_ON && !clk_off_q[0]
    |=> main_st[0] == PST_ON)
    else $error("Domain left on state without clock-off.");
  // Bus timing: a read waits exactly one cycle and a write never waits.
  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state was not exactly one cycle.");
  AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("Write inserted a wait state.");

  // Covers for power-down, flag clearing, pin action and a strapped-off start.
  COV_POWER_DOWN: cover property (main_st[0] == PST_GOING ##[1:200] main_st[0] == PST_OFF);
  COV_CLEAR_CMP: cover property (cmp_clr_wr && cmp_q != '0);
  COV_PIN: cover property ($fell(error_out_n));
  COV_STRAP_OFF: cover property ($rose(start) && strap_sync[3]);

endmodule

// File: test/ldp_tb.sv
// Self-checking testbench for the logic domain power-down controller.
// Assumes ldp_top on a single hclk, driven as the one master of its AHB-Lite port.
`timescale 1ns/100ps
module testbench;
  import ldp_pkg::*;
  // -------------------------------------------------------------
  // Stimulus and observed signals
  // -------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  ldp_htrans_t htrans = HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [NUM_DOM-1:0] strap_dom_off = 4'h8;
  logic irq;
  logic error_out_n;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // The single slave's ready is the bus ready, so waits come from the design alone.
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  ldp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .strap_dom_off(strap_dom_off),
    .irq(irq), .error_out_n(error_out_n));
  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus tasks start just after a rising edge and hold the phase until ready is seen high.
  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= HTRANS_IDLE; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= HTRANS_IDLE;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Strap of domain 3 is high, so it must come out of reset already off.
  task automatic t_reset_straps();
    check({28'h0, hresp, hreadyout, irq, error_out_n}, 32'h5);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_INIT, PST_INIT, PST_INIT, PST_INIT});
    idle(10);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_ON});
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h0);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h0);
    ahb_read(32'hFFFF0100, rd);
    check(rd, 32'h0);
  endtask
  // Code alone must not start power-down; clock-off plus code does, taking the delay.
  task automatic t_power_down();
    int t0;
    ahb_write(ADDR_PWR_CTRL, {28'h0, PWR_CODE_OFF});
    idle(PGOOD_CYCLES + 10);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_ON});
    ahb_write(ADDR_CLK_OFF_SET, 32'h1);
    t0 = cyc;
    idle(1);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_GOING});
    while (rd[1:0] !== PST_OFF && cyc - t0 < 400)
      ahb_read(ADDR_PWR_STATE, rd);
    check({31'h0, (cyc - t0 >= PGOOD_CYCLES - 2) && (cyc - t0 <= PGOOD_CYCLES + 10)}, 32'h1);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_OFF});
    ahb_write(ADDR_PWR_CTRL, 32'h0);
    idle(4);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_OFF});
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h0);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h0);
  endtask
  // Injected differences raise flags, which clear only by one-writes once the cause ends.
  task automatic t_flags_and_irq();
    ahb_write(ADDR_CMP_STATUS, 32'h000F0000);
    ahb_write(ADDR_ERR_STATUS, 32'h000000C0);
    ahb_write(ADDR_CMP_INJECT, 32'h4);
    idle(3);
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h00040000);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h00000080);
    check({30'h0, irq, error_out_n}, 32'h1);
    ahb_write(ADDR_CMP_STATUS, 32'h0);
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h00040000);
    ahb_write(ADDR_CMP_STATUS, 32'h000F0000);
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h00040000);
    // Channel 39 stays masked while only channel 38 raises the interrupt.
    ahb_write(ADDR_ERR_IRQ_EN_SET, 32'h40);
    idle(3);
    check({31'h0, irq}, 32'h0);
    ahb_write(ADDR_CMP_INJECT, 32'h5);
    idle(4);
    check({31'h0, irq}, 32'h1);
    ahb_write(ADDR_ERR_PIN_EN_SET, 32'h80);
    idle(3);
    check({31'h0, error_out_n}, 32'h0);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h000000C0);
    ahb_write(ADDR_CMP_INJECT, 32'h0);
    ahb_write(ADDR_ERR_STATUS, 32'h0);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h000000C0);
    ahb_write(ADDR_CMP_STATUS, 32'h000F0000);
    ahb_write(ADDR_ERR_STATUS, 32'h000000C0);
    idle(3);
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h0);
    ahb_read(ADDR_ERR_STATUS, rd);
    check(rd, 32'h0);
    check({30'h0, irq, error_out_n}, 32'h1);
  endtask
  // Only a system reset brings the software-disabled domain back on.
  task automatic t_second_reset();
    hresetn <= 1'b0;
    idle(3);
    hresetn <= 1'b1;
    idle(12);
    ahb_read(ADDR_PWR_STATE, rd);
    check(rd, {24'h0, PST_OFF, PST_ON, PST_ON, PST_ON});
    ahb_read(ADDR_ERR_IRQ_EN_SET, rd);
    check(rd, 32'h0);
    ahb_read(ADDR_CMP_STATUS, rd);
    check(rd, 32'h0);
    // No fault is injected here, so the flags are cleared at once.
    ahb_write(ADDR_CMP_STATUS, 32'h000F0000);
    ahb_write(ADDR_ERR_STATUS, 32'h000000C0);
    ahb_write(ADDR_ERR_IRQ_EN_SET, 32'hC0);
    ahb_write(ADDR_ERR_PIN_EN_SET, 32'hC0);
    idle(3);
    check({30'h0, irq, error_out_n}, 32'h1);
    ahb_read(ADDR_ERR_IRQ_EN_SET, rd);
    check(rd, 32'h000000C0);
  endtask
  // -------------------------------------------------------------
  // Main sequence and hang guard
  // -------------------------------------------------------------
  // The ceiling is generous: the whole run needs well under two thousand cycles.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    idle(8);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_straps();
    t_power_down();
    t_flags_and_irq();
    t_second_reset();
    report_and_stop();
  end
endmodule
